// ### sim/acc_far_side.sv
module acc_far_side
  import acc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Levels chosen by the bench
  input wire logic [ACC_LVL_W-1:0] pos_set,
  input wire logic [ACC_LVL_W-1:0] neg_set,
  input wire logic [7:0][ACC_LVL_W-1:0] mux_set,
  // Analogue pins seen by the block
  output logic [ACC_LVL_W-1:0] positive_input_pin,
  output logic [ACC_LVL_W-1:0] negative_input_pin,
  output logic [7:0][ACC_LVL_W-1:0] converter_pin_level,
  // Timer capture front end
  input wire logic capture_route_active,
  input wire logic capture_signal,
  input wire logic timer_capture_irq_enable,
  output logic [7:0] capture_count,
  output logic capture_irq
);
  logic cap_prev;
  logic cap_edge;

  // Pins are stiff sources, so levels follow at once
  assign positive_input_pin = pos_set;
  assign negative_input_pin = neg_set;
  assign converter_pin_level = mux_set;

  // Rising edge select only; the noise canceller is left out
  assign cap_edge = capture_route_active && capture_signal && !cap_prev;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cap_prev <= 1'b0;
      capture_count <= 8'h00;
    end else begin
      cap_prev <= capture_signal;
      if (cap_edge) begin
        capture_count <= capture_count + 8'h01;
      end
    end
  end

  // Capture interrupt also needs its own mask bit
  assign capture_irq = cap_edge && timer_capture_irq_enable;
endmodule // acc_far_side

// ### sim/test_analog_comparator_control.sv
module test_analog_comparator_control
  import acc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic reset_n, io_hit, converter_enable, converter_power_reduction;
  logic auto_trigger_enable, global_irq_enable, irq_vector_ack;
  logic comparator_irq, converter_trigger, capture_route_active;
  logic capture_signal, comparator_power_off, negative_from_mux;
  logic positive_from_bandgap, comparator_result, capture_irq, e;
  logic timer_capture_irq_enable;
  logic [1:0] pin_digital_in, pin_buffer_enable, port_input_bits;
  logic [2:0] channel_select, negative_mux_channel;
  logic [7:0] io_rdata, trigger_flags, capture_count;
  logic [7:0] seed = 8'h5C;
  logic [ACC_LVL_W-1:0] pos_set, neg_set, rp, rn;
  logic [ACC_LVL_W-1:0] positive_input_pin, negative_input_pin;
  logic [7:0][ACC_LVL_W-1:0] mux_set, mux_tmp, converter_pin_level;
  acc_io_req_t io_req;
  int num_errors = 0;
  int checks_done = 0;

  acc_core u_acc_core (
    .clk, .reset_n, .io_req, .io_rdata, .io_hit, .converter_enable,
    .channel_select, .converter_power_reduction, .auto_trigger_enable,
    .positive_input_pin, .negative_input_pin, .converter_pin_level,
    .global_irq_enable, .irq_vector_ack, .comparator_irq, .trigger_flags,
    .converter_trigger, .capture_route_active, .capture_signal,
    .pin_digital_in, .pin_buffer_enable, .port_input_bits,
    .comparator_power_off, .negative_from_mux, .negative_mux_channel,
    .positive_from_bandgap, .comparator_result
  );

  acc_far_side u_acc_far_side (
    .clk, .reset_n, .pos_set, .neg_set, .mux_set, .positive_input_pin,
    .negative_input_pin, .converter_pin_level, .capture_route_active,
    .capture_signal, .timer_capture_irq_enable, .capture_count, .capture_irq
  );

  always #2.5 clk = ~clk;

  function automatic logic [7:0] lfsr_step(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic exp_res(input logic [9:0] p, input logic [9:0] n,
                                   input logic bg, input logic off);
    return !off && ((bg ? ACC_BANDGAP_LVL : p) > n);
  endfunction

  task automatic rnd10(output logic [9:0] v);
    seed = lfsr_step(seed);
    v = {seed[1:0], seed};
  endtask

  task automatic check_byte(input string w, input logic [7:0] x,
                            input logic [7:0] g);
    checks_done++;
    if (g !== x) begin
      num_errors++;
      $display("Error %s expected %h seen %h", w, x, g);
    end
  endtask

  task automatic check_bit(input string w, input logic x, input logic g);
    check_byte(w, {7'h00, x}, {7'h00, g});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    io_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk);
    io_req <= '0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] x,
                        input string w);
    @(posedge clk);
    io_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    #1 check_bit("hit", a == ACC_OFS_CMP_CS || a == ACC_OFS_CNV_CSB ||
                 a == ACC_OFS_PIN_DIS, io_hit);
    @(posedge clk);
    io_req <= '0;
    #1 check_byte(w, x, io_rdata);
  endtask

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Guard against a hang anywhere in the sequence
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end

  initial begin
    io_req = '0;
    {converter_enable, converter_power_reduction, auto_trigger_enable} = '0;
    {global_irq_enable, irq_vector_ack, timer_capture_irq_enable} = '0;
    {channel_select, trigger_flags, pin_digital_in} = '0;
    // Mux pins sit high so an early mux enable keeps the result low
    mux_set = '1;
    pos_set = 10'h100;
    neg_set = 10'h100;
    reset_n = 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    rd_chk(ACC_OFS_CMP_CS, ACC_RST_CMP_CS, "cs reset");
    rd_chk(ACC_OFS_CNV_CSB, ACC_RST_CNV_CSB, "csb reset");
    rd_chk(ACC_OFS_PIN_DIS, ACC_RST_PIN_DIS, "dis reset");
    rd_chk(8'h51, 8'h00, "unmapped");
    reg_wr(ACC_OFS_CNV_CSB, 8'hFF);
    rd_chk(ACC_OFS_CNV_CSB, 8'h47, "csb");
    reg_wr(ACC_OFS_CNV_CSB, 8'h00);
    // Result bit is read only; levels are equal so it stays low
    reg_wr(ACC_OFS_CMP_CS, 8'h20);
    rd_chk(ACC_OFS_CMP_CS, 8'h00, "cs ro");
    // Random levels; equal levels and bandgap boundaries as corners
    for (int i = 0; i < 12; i++) begin
      reg_wr(ACC_OFS_CMP_CS, {i == 7, i[0], 6'h00});
      rnd10(rp);
      rnd10(rn);
      if (i == 0) rn = rp;
      if (i == 3) rn = ACC_BANDGAP_LVL - 10'h001;
      if (i == 5) rn = ACC_BANDGAP_LVL;
      @(posedge clk);
      pos_set <= rp;
      neg_set <= rn;
      cyc(2);
      e = exp_res(rp, rn, i[0], i == 7);
      #1 check_bit("result", e, comparator_result);
      check_bit("bandgap", i[0], positive_from_bandgap);
      check_bit("power off", i == 7, comparator_power_off);
    end
    reg_wr(ACC_OFS_CMP_CS, 8'h00);
    reg_wr(ACC_OFS_CNV_CSB, 8'h40);
    // Channels 0..7, then converter on, power reduction, mux off
    for (int j = 0; j < 11; j++) begin
      if (j == 10) reg_wr(ACC_OFS_CNV_CSB, 8'h00);
      for (int k = 0; k < 8; k++) rnd10(mux_tmp[k]);
      @(posedge clk);
      mux_set <= mux_tmp;
      pos_set <= 10'h200;
      neg_set <= 10'h1FF;
      channel_select <= j[2:0];
      converter_enable <= (j == 8);
      converter_power_reduction <= (j == 9);
      cyc(2);
      e = 10'h200 > (j < 8 ? mux_tmp[j[2:0]] : 10'h1FF);
      #1 check_bit("from mux", j < 8, negative_from_mux);
      check_bit("mux result", e, comparator_result);
      check_byte("mux channel", {5'h00, j[2:0]},
                 {5'h00, negative_mux_channel});
    end
    @(posedge clk);
    global_irq_enable <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      pos_set <= 10'h100;
      cyc(3);
      reg_wr(ACC_OFS_CMP_CS, {6'h04, m[1:0]});
      reg_wr(ACC_OFS_CMP_CS, {6'h06, m[1:0]});
      @(posedge clk);
      pos_set <= 10'h200;
      cyc(3);
      e = (m == 0) || (m == 3);
      #1 check_bit("rise irq", e, comparator_irq);
      @(posedge clk);
      global_irq_enable <= 1'b0;
      #1 check_bit("masked irq", 1'b0, comparator_irq);
      @(posedge clk);
      global_irq_enable <= 1'b1;
      irq_vector_ack <= 1'b1;
      @(posedge clk);
      irq_vector_ack <= 1'b0;
      #1 check_bit("ack irq", 1'b0, comparator_irq);
      @(posedge clk);
      pos_set <= 10'h100;
      cyc(3);
      e = (m == 0) || (m == 2);
      #1 check_bit("fall irq", e, comparator_irq);
      rd_chk(ACC_OFS_CMP_CS, {3'h0, e, 2'b10, m[1:0]}, "cs flag");
      reg_wr(ACC_OFS_CMP_CS, {6'h06, m[1:0]});
      #1 check_bit("w1c irq", 1'b0, comparator_irq);
      // Interrupt off before the mode changes, against spurious events
      reg_wr(ACC_OFS_CMP_CS, {6'h00, m[1:0]});
    end
    reg_wr(ACC_OFS_CMP_CS, 8'h04);
    timer_capture_irq_enable <= 1'b1;
    @(posedge clk);
    pos_set <= 10'h200;
    cyc(2);
    #1 check_bit("capture", 1'b1, capture_signal);
    check_bit("route", 1'b1, capture_route_active);
    check_bit("capture irq", 1'b1, capture_irq);
    reg_wr(ACC_OFS_CMP_CS, 8'h00);
    pos_set <= 10'h100;
    cyc(3);
    pos_set <= 10'h200;
    cyc(2);
    #1 check_bit("no capture", 1'b0, capture_signal);
    check_byte("capture count", 8'h01, capture_count);
    @(posedge clk);
    converter_enable <= 1'b1;
    auto_trigger_enable <= 1'b1;
    for (int s = 2; s < 8; s++) begin
      reg_wr(ACC_OFS_CNV_CSB, s[7:0]);
      @(posedge clk);
      trigger_flags <= 8'h01 << s;
      #1 check_bit("trigger", 1'b1, converter_trigger);
      @(posedge clk);
      #1 check_bit("one pulse", 1'b0, converter_trigger);
      @(posedge clk);
      trigger_flags <= 8'h00;
    end
    @(posedge clk);
    trigger_flags <= 8'h05;
    reg_wr(ACC_OFS_CNV_CSB, 8'h02);
    #1 check_bit("switch", 1'b1, converter_trigger);
    reg_wr(ACC_OFS_CNV_CSB, 8'h03);
    reg_wr(ACC_OFS_CNV_CSB, 8'h00);
    #1 check_bit("free run", 1'b0, converter_trigger);
    // Source 0 drops low so the next switch is a real rising edge
    @(posedge clk);
    trigger_flags <= 8'h00;
    reg_wr(ACC_OFS_CNV_CSB, 8'h03);
    auto_trigger_enable <= 1'b0;
    trigger_flags <= 8'h0D;
    #1 check_bit("no auto", 1'b0, converter_trigger);
    @(posedge clk);
    auto_trigger_enable <= 1'b1;
    converter_enable <= 1'b0;
    trigger_flags <= 8'h05;
    @(posedge clk);
    trigger_flags <= 8'h0D;
    #1 check_bit("conv off", 1'b0, converter_trigger);
    @(posedge clk);
    converter_enable <= 1'b1;
    trigger_flags <= 8'h00;
    pos_set <= 10'h100;
    reg_wr(ACC_OFS_CMP_CS, 8'h13);
    reg_wr(ACC_OFS_CNV_CSB, 8'h01);
    pos_set <= 10'h200;
    cyc(3);
    #1 check_bit("cmp trigger", 1'b1, converter_trigger);
    for (int d = 0; d < 4; d++) begin
      reg_wr(ACC_OFS_PIN_DIS, d[7:0]);
      seed = lfsr_step(seed);
      pin_digital_in <= seed[1:0];
      @(posedge clk);
      #1 check_byte("pins", {4'h0, ~d[1:0], seed[1:0] & ~d[1:0]},
                    {4'h0, pin_buffer_enable, port_input_bits});
    end
    rd_chk(ACC_OFS_PIN_DIS, 8'h03, "dis");
    report_and_stop();
  end
endmodule // test_analog_comparator_control

// ### src/acc_core.sv
module acc_core
  import acc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Processor I/O register access
  input wire acc_io_req_t io_req,
  output logic [7:0] io_rdata,
  output logic io_hit,
  // Converter state seen by the comparator
  input wire logic converter_enable,
  input wire logic [2:0] channel_select,
  input wire logic converter_power_reduction,
  input wire logic auto_trigger_enable,
  // Analogue levels, as sampled codes
  input wire logic [ACC_LVL_W-1:0] positive_input_pin,
  input wire logic [ACC_LVL_W-1:0] negative_input_pin,
  input wire logic [7:0][ACC_LVL_W-1:0] converter_pin_level,
  // Interrupt controller
  input wire logic global_irq_enable,
  input wire logic irq_vector_ack,
  output logic comparator_irq,
  // Trigger flags, index 0 is the converter flag
  input wire logic [7:0] trigger_flags,
  output logic converter_trigger,
  // Timer capture front end
  output logic capture_route_active,
  output logic capture_signal,
  // Comparator pins digital side
  input wire logic [1:0] pin_digital_in,
  output logic [1:0] pin_buffer_enable,
  output logic [1:0] port_input_bits,
  // Analogue control
  output logic comparator_power_off,
  output logic negative_from_mux,
  output logic [2:0] negative_mux_channel,
  output logic positive_from_bandgap,
  output logic comparator_result
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic power_off_reg;
  logic bandgap_select_reg;
  logic irq_flag_reg;
  logic irq_enable_reg;
  logic capture_enable_reg;
  acc_mode_t edge_mode_reg;
  logic mux_enable_reg;
  acc_trig_t trig_sel_reg;
  acc_trig_t trig_sel_prev_reg;
  logic [1:0] pin_disable_reg;
  logic trig_level_prev_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic wr_cs;
  logic wr_csb;
  logic wr_dis;
  logic [ACC_LVL_W-1:0] pos_level;
  logic [ACC_LVL_W-1:0] neg_level;
  logic raw_result;
  logic sync_result;
  logic sync_prev;
  logic cmp_event;
  logic flag_clear;
  logic trig_level;
  logic trig_rise;
  logic to_free_run;

  // Address decode
  always_comb begin
    wr_cs = 1'b0;
    wr_csb = 1'b0;
    wr_dis = 1'b0;
    if (io_req.addr == ACC_OFS_CMP_CS) begin
      wr_cs = io_req.wr;
    end else if (io_req.addr == ACC_OFS_CNV_CSB) begin
      wr_csb = io_req.wr;
    end else if (io_req.addr == ACC_OFS_PIN_DIS) begin
      wr_dis = io_req.wr;
    end
  end

  assign io_hit = (io_req.addr == ACC_OFS_CMP_CS) ||
                  (io_req.addr == ACC_OFS_CNV_CSB) ||
                  (io_req.addr == ACC_OFS_PIN_DIS);

  // Comparator control bits
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      power_off_reg <= ACC_RST_CMP_CS[ACC_CS_POWER_OFF];
      bandgap_select_reg <= ACC_RST_CMP_CS[ACC_CS_BANDGAP];
      irq_enable_reg <= ACC_RST_CMP_CS[ACC_CS_IRQ_EN];
      capture_enable_reg <= ACC_RST_CMP_CS[ACC_CS_CAPTURE];
      edge_mode_reg <= acc_mode_t'(
        ACC_RST_CMP_CS[ACC_CS_MODE_HI:ACC_CS_MODE_LO]);
    end else if (wr_cs) begin
      power_off_reg <= io_req.wdata[ACC_CS_POWER_OFF];
      bandgap_select_reg <= io_req.wdata[ACC_CS_BANDGAP];
      irq_enable_reg <= io_req.wdata[ACC_CS_IRQ_EN];
      capture_enable_reg <= io_req.wdata[ACC_CS_CAPTURE];
      edge_mode_reg <= acc_mode_t'(
        io_req.wdata[ACC_CS_MODE_HI:ACC_CS_MODE_LO]);
    end
  end

  // Converter control B bits
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mux_enable_reg <= ACC_RST_CNV_CSB[ACC_CSB_MUX_EN];
      trig_sel_reg <= acc_trig_t'(
        ACC_RST_CNV_CSB[ACC_CSB_TRIG_HI:ACC_CSB_TRIG_LO]);
    end else if (wr_csb) begin
      mux_enable_reg <= io_req.wdata[ACC_CSB_MUX_EN];
      trig_sel_reg <= acc_trig_t'(
        io_req.wdata[ACC_CSB_TRIG_HI:ACC_CSB_TRIG_LO]);
    end
  end

  // Pin input disable bits; upper bits are not stored
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_disable_reg <= ACC_RST_PIN_DIS[ACC_DIS_NEG:ACC_DIS_POS];
    end else if (wr_dis) begin
      pin_disable_reg <= io_req.wdata[ACC_DIS_NEG:ACC_DIS_POS];
    end
  end

  // Input selection
  assign negative_from_mux = mux_enable_reg && !converter_enable &&
                             !converter_power_reduction;
  assign negative_mux_channel = channel_select;
  assign positive_from_bandgap = bandgap_select_reg;
  assign pos_level = bandgap_select_reg ? ACC_BANDGAP_LVL :
                     positive_input_pin;
  assign neg_level = negative_from_mux ?
                     converter_pin_level[channel_select] :
                     negative_input_pin;

  // Powered-off comparator is held low
  assign raw_result = !power_off_reg && (pos_level > neg_level);
  assign comparator_power_off = power_off_reg;

  acc_sync_edge u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(raw_result),
    .level_out(sync_result),
    .level_prev(sync_prev)
  );

  assign comparator_result = sync_result;

  // Event detection on synchronised samples
  always_comb begin
    cmp_event = 1'b0;
    case (edge_mode_reg)
      ACC_MODE_TOGGLE: cmp_event = sync_result != sync_prev;
      ACC_MODE_FALL: cmp_event = !sync_result && sync_prev;
      ACC_MODE_RISE: cmp_event = sync_result && !sync_prev;
      default: cmp_event = 1'b0;
    endcase
  end

  assign flag_clear = irq_vector_ack ||
                      (wr_cs && io_req.wdata[ACC_CS_FLAG]);

  // A new event wins over a clear in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_flag_reg <= ACC_RST_CMP_CS[ACC_CS_FLAG];
    end else if (cmp_event) begin
      irq_flag_reg <= 1'b1;
    end else if (flag_clear) begin
      irq_flag_reg <= 1'b0;
    end
  end

  assign comparator_irq = irq_flag_reg && irq_enable_reg &&
                          global_irq_enable;

  // Capture routing; timer mask is outside this block
  assign capture_route_active = capture_enable_reg;
  assign capture_signal = capture_enable_reg && sync_result;

  // Auto trigger: comparator flag replaces the external index 1
  always_comb begin
    trig_level = trigger_flags[trig_sel_reg];
    if (trig_sel_reg == ACC_TRIG_CMP) begin
      trig_level = irq_flag_reg;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trig_level_prev_reg <= 1'b0;
      trig_sel_prev_reg <= ACC_TRIG_FREE;
    end else begin
      trig_level_prev_reg <= trig_level;
      trig_sel_prev_reg <= trig_sel_reg;
    end
  end

  // Previous level is that of the previous selection, so a switch counts
  assign trig_rise = trig_level && !trig_level_prev_reg;
  assign to_free_run = (trig_sel_reg == ACC_TRIG_FREE) &&
                       (trig_sel_prev_reg != ACC_TRIG_FREE);
  assign converter_trigger = auto_trigger_enable && converter_enable &&
                             trig_rise && !to_free_run;

  // Digital input buffers
  assign pin_buffer_enable = ~pin_disable_reg;
  assign port_input_bits = pin_digital_in & ~pin_disable_reg;

  // Read data, registered; unmapped reads return zero
  always_comb begin
    rdata_next = 8'h00;
    if (io_req.addr == ACC_OFS_CMP_CS) begin
      rdata_next[ACC_CS_POWER_OFF] = power_off_reg;
      rdata_next[ACC_CS_BANDGAP] = bandgap_select_reg;
      rdata_next[ACC_CS_RESULT] = sync_result;
      rdata_next[ACC_CS_FLAG] = irq_flag_reg;
      rdata_next[ACC_CS_IRQ_EN] = irq_enable_reg;
      rdata_next[ACC_CS_CAPTURE] = capture_enable_reg;
      rdata_next[ACC_CS_MODE_HI:ACC_CS_MODE_LO] = edge_mode_reg;
    end else if (io_req.addr == ACC_OFS_CNV_CSB) begin
      rdata_next[ACC_CSB_MUX_EN] = mux_enable_reg;
      rdata_next[ACC_CSB_TRIG_HI:ACC_CSB_TRIG_LO] = trig_sel_reg;
    end else if (io_req.addr == ACC_OFS_PIN_DIS) begin
      rdata_next[ACC_DIS_NEG:ACC_DIS_POS] = pin_disable_reg;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 8'h00;
    end else if (io_req.rd) begin
      rdata_reg <= rdata_next;
    end
  end

  assign io_rdata = rdata_reg;

  // Checks

  property p_result_level;
    (pos_level > neg_level) && !power_off_reg |-> raw_result;
  endproperty
  a_result_level: assert property (p_result_level)
    else $error("raw result low although positive level is higher");

  property p_neg_mux;
    mux_enable_reg && !converter_enable && !converter_power_reduction |->
      neg_level == converter_pin_level[channel_select];
  endproperty
  a_neg_mux: assert property (p_neg_mux)
    else $error("negative input not taken from selected pin");

  property p_neg_pin;
    !mux_enable_reg || converter_enable |-> neg_level == negative_input_pin;
  endproperty
  a_neg_pin: assert property (p_neg_pin)
    else $error("negative input not taken from dedicated pin");

  property p_bandgap;
    bandgap_select_reg |-> pos_level == ACC_BANDGAP_LVL;
  endproperty
  a_bandgap: assert property (p_bandgap)
    else $error("bandgap not used as positive input");

  property p_sync_delay;
    ##2 (comparator_result == $past(raw_result, 2));
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("synchronised result does not follow raw result");

  property p_rise_flag;
    edge_mode_reg == ACC_MODE_RISE && $rose(comparator_result) |=>
      irq_flag_reg;
  endproperty
  a_rise_flag: assert property (p_rise_flag)
    else $error("rising edge did not set flag");

  property p_reserved_mode;
    edge_mode_reg == ACC_MODE_RSVD && !irq_flag_reg &&
      !(wr_cs || wr_csb) |=> !irq_flag_reg;
  endproperty
  a_reserved_mode: assert property (p_reserved_mode)
    else $error("reserved mode set the flag");

  property p_clear_ack;
    irq_vector_ack && !cmp_event |=> !irq_flag_reg;
  endproperty
  a_clear_ack: assert property (p_clear_ack)
    else $error("flag not cleared by vector entry");

  property p_irq;
    comparator_irq == (irq_flag_reg && irq_enable_reg && global_irq_enable);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt request mismatch");

  property p_capture_off;
    !capture_enable_reg |-> !capture_signal;
  endproperty
  a_capture_off: assert property (p_capture_off)
    else $error("capture driven while routing disabled");

  property p_no_trig_disabled;
    !auto_trigger_enable |-> !converter_trigger;
  endproperty
  a_no_trig_disabled: assert property (p_no_trig_disabled)
    else $error("trigger with auto trigger disabled");

  property p_free_switch;
    trig_sel_reg == ACC_TRIG_FREE && $past(trig_sel_reg) != ACC_TRIG_FREE
      |-> !converter_trigger;
  endproperty
  a_free_switch: assert property (p_free_switch)
    else $error("switch to free running made a trigger");

  property p_pin_disable;
    pin_disable_reg[ACC_DIS_POS] |-> !port_input_bits[ACC_DIS_POS] &&
      !pin_buffer_enable[ACC_DIS_POS];
  endproperty
  a_pin_disable: assert property (p_pin_disable)
    else $error("disabled pin input not forced to zero");

endmodule // acc_core

// ### src/acc_pkg.sv
package acc_pkg;

  // Register offsets in the processor I/O data space
  localparam logic [7:0] ACC_OFS_CMP_CS = 8'h50;
  localparam logic [7:0] ACC_OFS_CNV_CSB = 8'h7B;
  localparam logic [7:0] ACC_OFS_PIN_DIS = 8'h7F;

  // Comparator control and status fields
  localparam int ACC_CS_POWER_OFF = 7;
  localparam int ACC_CS_BANDGAP = 6;
  localparam int ACC_CS_RESULT = 5;
  localparam int ACC_CS_FLAG = 4;
  localparam int ACC_CS_IRQ_EN = 3;
  localparam int ACC_CS_CAPTURE = 2;
  localparam int ACC_CS_MODE_HI = 1;
  localparam int ACC_CS_MODE_LO = 0;

  // Converter control and status B fields
  localparam int ACC_CSB_MUX_EN = 6;
  localparam int ACC_CSB_TRIG_HI = 2;
  localparam int ACC_CSB_TRIG_LO = 0;

  // Pin input disable fields
  localparam int ACC_DIS_NEG = 1;
  localparam int ACC_DIS_POS = 0;

  // Reset values
  localparam logic [7:0] ACC_RST_CMP_CS = 8'h00;
  localparam logic [7:0] ACC_RST_CNV_CSB = 8'h00;
  localparam logic [7:0] ACC_RST_PIN_DIS = 8'h00;

  // Analogue level width and the fixed bandgap level
  localparam int ACC_LVL_W = 10;
  localparam logic [ACC_LVL_W-1:0] ACC_BANDGAP_LVL = 10'h0E1;

  // Synchroniser depth: two flops, 1 to 2 cycle delay
  localparam int ACC_SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    ACC_MODE_TOGGLE = 2'b00,
    ACC_MODE_RSVD = 2'b01,
    ACC_MODE_FALL = 2'b10,
    ACC_MODE_RISE = 2'b11
  } acc_mode_t;

  typedef enum logic [2:0] {
    ACC_TRIG_FREE = 3'b000,
    ACC_TRIG_CMP = 3'b001,
    ACC_TRIG_EXT0 = 3'b010,
    ACC_TRIG_T0_CMPA = 3'b011,
    ACC_TRIG_T0_OVF = 3'b100,
    ACC_TRIG_T1_CMPB = 3'b101,
    ACC_TRIG_T1_OVF = 3'b110,
    ACC_TRIG_T1_CAPT = 3'b111
  } acc_trig_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } acc_io_req_t;

endpackage : acc_pkg

// ### src/acc_sync_edge.sv
module acc_sync_edge
  import acc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Asynchronous level in
  input wire logic async_in,
  // Synchronised level and its previous sample
  output logic level_out,
  output logic level_prev
);

  logic [ACC_SYNC_STAGES-1:0] stage_reg;
  logic prev_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage_reg <= '0;
    end else begin
      stage_reg <= {stage_reg[ACC_SYNC_STAGES-2:0], async_in};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= stage_reg[ACC_SYNC_STAGES-1];
    end
  end

  assign level_out = stage_reg[ACC_SYNC_STAGES-1];
  assign level_prev = prev_reg;

endmodule // acc_sync_edge
